//--- src/dvm_address_mapper.sv
/*
 * packs and unpacks two-part maintenance message addresses for every
 * supported physical/virtual width pair.
 * pack and unpack results are registered; valids follow their requests one cycle later.
 * assumes handshake and message type handling live outside; one clock.
 * assumes the width parameters are fixed for a build, so the size
 * status is a constant once reset is released.
 * assumes ctrl carries first-transaction bits 15:0 as the issuer wants
 * them, bit 0 excepted, which the mapper drives itself.
 */
`default_nettype none
module dvm_address_mapper
    import dvm_addr_pkg::*;
#(
    parameter int unsigned PA_BITS = 48,
    parameter int unsigned VA_BITS = 57,
    parameter bit VERSION8 = 1'b1,
    parameter bit ASID16 = 1'b1
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // pack side
    input wire logic pack_req_i,
    input wire dvm_msg_s msg_i,
    output dvm_pair_s pair_o,
    output logic pair_vld_o,
    // unpack side
    input wire logic unpack_req_i,
    input wire dvm_pair_s rx_pair_i,
    input wire logic rx_is_pa_i,
    output dvm_msg_s rx_msg_o,
    output logic rx_vld_o,
    // status
    output logic size_ok_o,
    output logic size_err_o
);
    logic ok;
    dvm_pair_s pair_d;
    dvm_msg_s rx_d;
    logic [VA_W-1:0] va_mask;

    // upper address groups that exist for this build's widths
    localparam bit WIDE_VA = (VA_BITS > SZ_32);
    localparam bit HAS_PA40 = (PA_BITS >= SZ_40);
    localparam bit HAS_PA44 = (PA_BITS >= SZ_44);
    localparam bit HAS_PA48 = (PA_BITS >= SZ_48);

    // width pair legality, fixed for a build
    dvm_size_check u_check (
        .pa_bits_i(6'(PA_BITS)),
        .va_bits_i(6'(VA_BITS)),
        .v8_i(VERSION8),
        .ok_o(ok)
    );

    // mask of bits that exist for a given width
    function automatic logic [VA_W-1:0] width_mask(input int unsigned w);
        width_mask = (w >= VA_W) ? '1 : ((VA_W'(1) << w) - VA_W'(1));
    endfunction

    // hint messages are exempt from the identifier-valid clears
    function automatic logic is_hint(input logic [15:0] ctrl);
        is_hint = (ctrl[TYPE_LO +: 3] == TYPE_HINT);
    endfunction

    // virtual bits this build keeps on receive
    assign va_mask = width_mask(VA_BITS);

    // pack one message into its two bus addresses
    always_comb begin
        logic hint;
        logic wide;
        hint = 1'b0;
        wide = WIDE_VA;
        pair_d = '0;
        hint = is_hint(msg_i.ctrl);
        pair_d.first[15:0] = msg_i.ctrl;
        pair_d.first[BIT_MORE] = 1'b1;
        pair_d.two_part = 1'b1;
        if (msg_i.form == MSG_PA) begin
            // virtual index, everything above 31 left zero
            pair_d.first[31:24] = msg_i.va[27:20];
            pair_d.first[23:16] = msg_i.va[19:12];
            pair_d.second[31:4] = msg_i.pa[31:4];
            // only the groups that the physical width reaches are sent
            if (HAS_PA40) pair_d.second[39:32] = msg_i.pa[39:32];
            if (HAS_PA44) pair_d.second[43:40] = msg_i.pa[43:40];
            if (HAS_PA48) pair_d.second[47:44] = msg_i.pa[47:44];
        end else if (msg_i.form == MSG_VA) begin
            pair_d.first[31:24] = msg_i.virtual_machine_identifier;
            pair_d.first[23:16] = msg_i.address_space_identifier[7:0];
            // high identifier byte only where a wide bus can carry it
            if (VERSION8 && ASID16 && wide && HAS_PA40) begin
                pair_d.first[39:32] =
                    msg_i.address_space_identifier[15:8];
            end // otherwise stays zero
            // upper virtual bits are split across both parts and shifted
            // by one, so a narrower receiver just drops whole groups
            if (HAS_PA44) pair_d.first[43:40] = msg_i.va[48:45];
            if (HAS_PA48) pair_d.first[47:44] = msg_i.va[56:53];
            pair_d.second[31:4] = msg_i.va[31:4];
            if (wide) begin
                pair_d.second[3] = msg_i.va[40];
                pair_d.second[39:32] = msg_i.va[39:32];
                if (HAS_PA44) pair_d.second[43:40] = msg_i.va[44:41];
                if (HAS_PA48) pair_d.second[47:44] = msg_i.va[52:49];
            end // 32-bit virtual leaves 39:32 and bit 3 zero
        end else begin
            // single-part message, no second address
            pair_d.first[BIT_MORE] = 1'b0;
            pair_d.two_part = 1'b0;
        end
        // zero clears come after every field write, so they win over any field; hint exempt
        if (!hint && !msg_i.ctrl[BIT_ADDRESS_SPACE_IDENTIFIER_VLD]) begin
            pair_d.first[23:16] = 8'h00;
            pair_d.first[39:32] = 8'h00;
        end
        if (!hint && !msg_i.ctrl[BIT_VIRTUAL_MACHINE_IDENTIFIER_VLD]) begin
            pair_d.first[31:24] = 8'h00;
        end
        // unsupported widths: nothing packed and no valid
        if (!ok) begin
            pair_d = '0;
        end
    end

    // unpack a received pair, dropping unsupported bits
    always_comb begin
        rx_d = '0;
        rx_d.ctrl = rx_pair_i.first[15:0];
        if (!rx_pair_i.two_part) begin
            rx_d.form = MSG_NONE;
        end else if (rx_is_pa_i) begin
            rx_d.form = MSG_PA;
            // virtual index only; physical form carries no identifiers
            rx_d.va[27:12] = rx_pair_i.first[31:16];
            rx_d.pa[BUS_AW-1:4] = rx_pair_i.second[BUS_AW-1:4];
            rx_d.pa = rx_d.pa & PA_W'(width_mask(PA_BITS));
        end else begin
            rx_d.form = MSG_VA;
            rx_d.virtual_machine_identifier = rx_pair_i.first[31:24];
            rx_d.address_space_identifier = {rx_pair_i.first[39:32],
                                             rx_pair_i.first[23:16]};
            rx_d.va[56:53] = rx_pair_i.first[47:44];
            rx_d.va[48:45] = rx_pair_i.first[43:40];
            rx_d.va[52:49] = rx_pair_i.second[47:44];
            rx_d.va[44:41] = rx_pair_i.second[43:40];
            rx_d.va[40] = rx_pair_i.second[3];
            rx_d.va[39:4] = rx_pair_i.second[39:4];
            // bits beyond this build's virtual width are dropped; a wider
            // sender's extra bits only cause over-invalidation
            rx_d.va = rx_d.va & va_mask;
            if (!ASID16) begin
                rx_d.address_space_identifier[15:8] = 8'h00;
            end
        end
    end

    // registered pack result
    // data holds between requests so a slow far side still sees it
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pair_o <= '0;
            pair_vld_o <= 1'b0;
        end else begin
            pair_vld_o <= pack_req_i && ok;
            if (pack_req_i) begin
                pair_o <= pair_d;
            end
        end
    end

    // registered unpack result
    // valid only for supported widths; data zero otherwise
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_msg_o <= '0;
            rx_vld_o <= 1'b0;
        end else begin
            rx_vld_o <= unpack_req_i && ok;
            if (unpack_req_i) begin
                rx_msg_o <= ok ? rx_d : '0;
            end
        end
    end

    // size status
    // constant from the first edge on, as the widths are fixed
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            size_ok_o <= 1'b0;
            size_err_o <= 1'b0;
        end else begin
            size_ok_o <= ok;
            size_err_o <= !ok;
        end
    end
endmodule
`default_nettype wire

//--- shared/dvm_addr_pkg.sv
/*
 * package for the two-part maintenance message address mapper:
 * address field positions, supported sizes and carrier structs.
 * assumes a 48-bit wide read address bus on the issuing side.
 */
`default_nettype none
package dvm_addr_pkg;
    localparam int unsigned BUS_AW = 48;
    localparam int unsigned VA_W = 57;
    localparam int unsigned PA_W = 48;
    // supported physical/virtual widths
    localparam int unsigned SZ_32 = 32;
    localparam int unsigned SZ_40 = 40;
    localparam int unsigned SZ_41 = 41;
    localparam int unsigned SZ_44 = 44;
    localparam int unsigned SZ_48 = 48;
    localparam int unsigned SZ_49 = 49;
    localparam int unsigned SZ_57 = 57;
    // first transaction control bit positions
    localparam int unsigned BIT_MORE = 0;
    localparam int unsigned BIT_ADDRESS_SPACE_IDENTIFIER_VLD = 5;
    localparam int unsigned BIT_VIRTUAL_MACHINE_IDENTIFIER_VLD = 6;
    localparam int unsigned TYPE_LO = 12;
    localparam logic [2:0] TYPE_HINT = 3'h6;
    localparam logic [BUS_AW-1:0] ADDR_RST = 48'h0000_0000_0000;

    typedef enum logic [1:0] {
        MSG_VA,
        MSG_PA,
        MSG_NONE
    } msg_form_e;

    // message fields handed in by the issuer
    typedef struct packed {
        msg_form_e form;
        logic [15:0] address_space_identifier;
        logic [7:0] virtual_machine_identifier;
        logic [VA_W-1:0] va;
        logic [PA_W-1:0] pa;
        logic [15:0] ctrl; // first transaction bits 15:0
    } dvm_msg_s;

    // two bus addresses produced for one message
    typedef struct packed {
        logic [BUS_AW-1:0] first;
        logic [BUS_AW-1:0] second;
        logic two_part;
    } dvm_pair_s;
endpackage
`default_nettype wire

//--- src/dvm_size_check.sv
/*
 * checks a physical/virtual width pair against the supported set.
 * assumes widths are constant during operation.
 */
`default_nettype none
module dvm_size_check
    import dvm_addr_pkg::*;
(
    // configuration
    input wire logic [5:0] pa_bits_i,
    input wire logic [5:0] va_bits_i,
    input wire logic v8_i,
    // result
    output logic ok_o
);
    // legal pairs, version 7 limited to 32-bit virtual
    always_comb begin
        ok_o = 1'b0;
        if (va_bits_i == 6'(SZ_32) &&
            (pa_bits_i == 6'(SZ_32) || pa_bits_i == 6'(SZ_40))) begin
            ok_o = 1'b1;
        end else if (v8_i) begin
            ok_o = (pa_bits_i == 6'(SZ_40) && va_bits_i == 6'(SZ_41)) ||
                   (pa_bits_i == 6'(SZ_44) && va_bits_i == 6'(SZ_49)) ||
                   (pa_bits_i == 6'(SZ_48) && va_bits_i == 6'(SZ_57));
        end
    end
endmodule
`default_nettype wire

//--- verification/dvm_address_mapper_sva.sv
/* assertions on the address mapper ports.
   assumes the default 48/57 version-8 build with wide identifiers. */
`default_nettype none
module dvm_address_mapper_chk
    import dvm_addr_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic pack_req_i,
    input wire dvm_msg_s msg_i,
    input wire dvm_pair_s pair_o,
    input wire logic pair_vld_o,
    input wire logic size_ok_o,
    input wire logic size_err_o
);
    timeunit 1ns;
    timeprecision 1ns;
    dvm_msg_s m_q;
    // request as taken, for use one cycle later
    always_ff @(posedge ref_clk_i) m_q <= msg_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    sequence va_req; pack_req_i && msg_i.form == MSG_VA; endsequence
    sequence pa_req; pack_req_i && msg_i.form == MSG_PA; endsequence
    sequence plain; pack_req_i && msg_i.ctrl[14:12] != TYPE_HINT; endsequence
    a_pack_answer: assert property (pack_req_i |=> pair_vld_o)
        else $error("pack not answered");
    a_more_flag: assert property (pair_vld_o |->
        pair_o.first[0] == pair_o.two_part) else $error("bit 0 wrong");
    a_va_upper: assert property (va_req ##0 msg_i.ctrl[5] |=>
        pair_o.first[47:32] == {m_q.va[56:53], m_q.va[48:45],
        m_q.address_space_identifier[15:8]}) else $error("upper first");
    a_va_second: assert property (va_req |=>
        pair_o.second[47:3] == {m_q.va[52:49], m_q.va[44:41],
        m_q.va[39:4], m_q.va[40]}) else $error("va second");
    a_clear_bit5: assert property (plain ##0 !msg_i.ctrl[5] |=>
        pair_o.first[23:16] == 0 && pair_o.first[39:32] == 0)
        else $error("bit 5 clear");
    a_clear_bit6: assert property (plain ##0 !msg_i.ctrl[6] |=>
        pair_o.first[31:24] == 0) else $error("bit 6 clear");
    a_pa_second: assert property (pa_req |=>
        pair_o.second[47:4] == m_q.pa[47:4]) else $error("pa second");
    a_pa_index: assert property (
        pa_req ##0 msg_i.ctrl[6:5] == 2'b11 |=>
        pair_o.first[47:16] == {16'h0000, m_q.va[27:12]})
        else $error("pa index");
    a_size_good: assert property ($past(nrst_i) |-> size_ok_o
        && !size_err_o) else $error("size status");
endmodule
bind dvm_address_mapper dvm_address_mapper_chk chk_u (.ref_clk_i,
    .nrst_i, .pack_req_i, .msg_i, .pair_o, .pair_vld_o, .size_ok_o,
    .size_err_o);
`default_nettype wire

//--- verification/dvm_rx_model.sv
/* far-side receiver: hands each packed pair back for unpacking.
   assumes pairs arrive as one-cycle valid pulses. */
`default_nettype none
module dvm_rx_model
    import dvm_addr_pkg::*;
(
    input wire logic clk_i,
    input wire dvm_pair_s pair_i,
    input wire logic vld_i,
    output logic req_o,
    output dvm_pair_s rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        req_o = 1'b0;
        rx_o = '0;
    end
    // one cycle of fresh pair, then inverted again on every cycle once released
    always @(negedge clk_i) begin
        req_o <= vld_i;
        rx_o <= vld_i ? pair_i : ~rx_o;
    end
endmodule
`default_nettype wire

//--- verification/test_dvm_address_mapper.sv
/* bench: packs va, pa, hint and bare messages, loops them back.
   assumes the mapper's default parameters. */
`default_nettype none
module test_dvm_address_mapper
    import dvm_addr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
    logic clk = 0, nrst = 0, pack = 0, unpack, is_pa = 0;
    logic vld, rx_vld, ok, err;
    dvm_msg_s msg = '0, rx_msg;
    dvm_pair_s pair, rx_pair;
    int failures = 0, n_checks = 0;
    dvm_address_mapper dut_u (.ref_clk_i(clk), .nrst_i(nrst),
        .pack_req_i(pack), .msg_i(msg), .pair_o(pair), .pair_vld_o(vld),
        .unpack_req_i(unpack), .rx_pair_i(rx_pair), .rx_is_pa_i(is_pa),
        .rx_msg_o(rx_msg), .rx_vld_o(rx_vld), .size_ok_o(ok),
        .size_err_o(err));
    dvm_rx_model rx_u (.clk_i(clk), .pair_i(pair), .vld_i(vld),
        .req_o(unpack), .rx_o(rx_pair));
    initial forever #50 clk = ~clk;
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // pack one message, then wait for its loop-back
    task automatic send(input msg_form_e f, input logic [15:0] c);
        @(negedge clk);
        msg.form = f;
        msg.ctrl = c;
        is_pa = (f == MSG_PA);
        pack = 1'b1;
        @(negedge clk);
        pack = 1'b0;
        `CHK(vld, 1'b1)
        @(negedge clk);
        `CHK(rx_vld, 1'b1)
    endtask
    initial begin
        #20000;
        failures++;
        final_report();
    end
    initial begin
        msg.address_space_identifier = 16'hA5C3;
        msg.virtual_machine_identifier = 8'h7E;
        msg.va = 57'h1AB_CDEF_0123_4567;
        msg.pa = 48'h9876_5432_10FE;
        repeat (16) @(negedge clk);
        `CHK({ok, err, vld}, 3'b000)
        nrst = 1'b1;
        @(negedge clk);
        `CHK({ok, err}, 2'b10)
        send(MSG_VA, 16'h0060);
        `CHK(pair.first[47:0], {msg.va[56:53], msg.va[48:45],
            msg.address_space_identifier[15:8], msg.virtual_machine_identifier,
            msg.address_space_identifier[7:0], 16'h0061})
        `CHK(pair.second[47:3], {msg.va[52:49], msg.va[44:41],
            msg.va[39:4], msg.va[40]})
        `CHK(rx_msg.va, {msg.va[56:4], 4'h0})
        `CHK({rx_msg.virtual_machine_identifier,
            rx_msg.address_space_identifier}, {msg.virtual_machine_identifier,
            msg.address_space_identifier})
        $display("va test done");
        for (int t = 0; t < 5; t++) begin
            send(MSG_VA, {1'b0, 3'(t), 12'h000});
            `CHK(pair.first[39:16], 24'h00_0000)
        end
        send(MSG_VA, 16'h6000);
        `CHK(pair.first[31:16], {msg.virtual_machine_identifier,
            msg.address_space_identifier[7:0]})
        `CHK(pair.first[39:32], msg.address_space_identifier[15:8])
        $display("clear test done");
        send(MSG_PA, 16'h2060);
        `CHK(pair.second[47:4], msg.pa[47:4])
        `CHK(pair.first[47:16], {16'h0000, msg.va[27:12]})
        `CHK(rx_msg.pa[47:4], msg.pa[47:4])
        $display("pa test done");
        send(MSG_NONE, 16'h4001);
        `CHK({pair.two_part, pair.first[0]}, 2'b00)
        $display("bare test done");
        final_report();
    end
endmodule
`default_nettype wire
